// ==== rtl/ext_irq_pkg.sv ====
// Constants, types and register map for the external pin interrupt block
package ext_irq_pkg;

    localparam int NUM_LINES = 4;
    localparam int ADDR_W    = 2;

    localparam logic [ADDR_W-1:0] SENSE_ADDR  = 2'h0;
    localparam logic [ADDR_W-1:0] ENABLE_ADDR = 2'h1;
    localparam logic [ADDR_W-1:0] FLAG_ADDR   = 2'h2;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 2'h3;

    localparam logic [7:0] SENSE_RESET  = 8'h00;
    localparam logic [3:0] ENABLE_RESET = 4'h0;
    localparam logic [3:0] FLAG_RESET   = 4'h0;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Two watchdog samples confirm a wake level
    localparam int WAKE_SAMPLES = 2;

    typedef enum logic [1:0] {
        SENSE_LOW     = 2'h0,
        SENSE_CHANGE  = 2'h1,
        SENSE_FALLING = 2'h2,
        SENSE_RISING  = 2'h3
    } sense_mode_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } reg_req_s;

endpackage : ext_irq_pkg

// ==== rtl/wake_level_sampler.sv ====
// Power-down level wake detector sampled on the watchdog oscillator tick
module wake_level_sampler #(
    parameter int NUM_LINES = 4
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Watchdog tick and line state
    input  wire logic                 wdt_tick,
    input  wire logic                 powered_down,
    input  wire logic [NUM_LINES-1:0] level_armed,
    input  wire logic [NUM_LINES-1:0] pin_sync,
    // Result
    output logic                      wake_req
);

    logic [NUM_LINES-1:0] seen_q;
    logic                 wake_q;

    // A low pin must survive two consecutive watchdog samples
    always_ff @(posedge clk) begin
        if (rst || !powered_down) begin
            seen_q <= '0;
        end else if (wdt_tick) begin
            seen_q <= level_armed & ~pin_sync;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !powered_down) begin
            wake_q <= 1'b0;
        end else if (wdt_tick && |(seen_q & level_armed & ~pin_sync)) begin
            wake_q <= 1'b1;
        end
    end

    assign wake_req = wake_q;

endmodule : wake_level_sampler

// ==== rtl/ext_pin_irq.sv ====
// External pin interrupt controller: sensing, flags, mask and register port
module ext_pin_irq #(
    parameter int NUM_LINES = ext_irq_pkg::NUM_LINES
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // External interrupt pins, seen whatever their direction
    input  wire logic [NUM_LINES-1:0]          ext_irq_pins,
    // Clock and power state
    input  wire logic                          io_clk_run,
    input  wire logic                          powered_down,
    input  wire logic                          wdt_tick,
    input  wire logic                          global_irq_enable,
    // Register port
    input  wire ext_irq_pkg::reg_req_s         reg_req,
    output logic [7:0]                         reg_rdata,
    // Dispatch handshake
    output logic [NUM_LINES-1:0]               irq_req,
    input  wire logic [NUM_LINES-1:0]          irq_ack,
    // Wake-up request to power management
    output logic                               wake_req
);

    logic [NUM_LINES-1:0]   sync1_q;
    logic [NUM_LINES-1:0]   sync2_q;
    logic [NUM_LINES-1:0]   prev_q;
    logic [7:0]             sense_control_reg_q;
    logic [NUM_LINES-1:0]   line_enable_reg_q;
    logic [NUM_LINES-1:0]   line_pending_flags_q;
    logic [NUM_LINES-1:0]   irq_req_q;
    logic [7:0]             rdata_q;
    logic                   wake_q;
    logic [NUM_LINES-1:0]   edge_hit;
    logic [NUM_LINES-1:0]   level_line;
    logic [NUM_LINES-1:0]   level_armed;
    logic [NUM_LINES-1:0]   req_d;
    logic                   wake_raw;
    logic                   wr_sense;
    logic                   wr_enable;
    logic                   wr_flag;

    function automatic ext_irq_pkg::sense_mode_e sense_of(
        input logic [7:0] ctl,
        input int         line
    );
        return ext_irq_pkg::sense_mode_e'(ctl[2*line +: 2]);
    endfunction : sense_of

    assign wr_sense  = reg_req.wr && reg_req.addr == ext_irq_pkg::SENSE_ADDR;
    assign wr_enable = reg_req.wr && reg_req.addr == ext_irq_pkg::ENABLE_ADDR;
    assign wr_flag   = reg_req.wr && reg_req.addr == ext_irq_pkg::FLAG_ADDR;

    // Pins sampled before any edge logic looks at them
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= ext_irq_pins;
            sync2_q <= sync1_q;
        end
    end

    // Previous sample only advances with the I/O clock, so edges freeze in sleep
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_q <= '0;
        end else if (io_clk_run) begin
            prev_q <= sync2_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_LINES; g++) begin : g_line
            always_comb begin
                edge_hit[g]   = 1'b0;
                level_line[g] = 1'b0;
                case (sense_of(sense_control_reg_q, g))
                    ext_irq_pkg::SENSE_LOW:     level_line[g] = 1'b1;
                    ext_irq_pkg::SENSE_CHANGE:  edge_hit[g] = sync2_q[g] ^ prev_q[g];
                    ext_irq_pkg::SENSE_FALLING: edge_hit[g] = prev_q[g] & ~sync2_q[g];
                    ext_irq_pkg::SENSE_RISING:  edge_hit[g] = ~prev_q[g] & sync2_q[g];
                    default:                    edge_hit[g] = 1'b0;
                endcase
                edge_hit[g] = edge_hit[g] & io_clk_run;
            end
        end
    endgenerate

    assign level_armed = level_line & line_enable_reg_q;

    // Sense fields, line 3 at the top pair
    always_ff @(posedge clk) begin
        if (rst) begin
            sense_control_reg_q <= ext_irq_pkg::SENSE_RESET;
        end else if (wr_sense) begin
            sense_control_reg_q <= reg_req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            line_enable_reg_q <= NUM_LINES'(ext_irq_pkg::ENABLE_RESET);
        end else if (wr_enable) begin
            line_enable_reg_q <= reg_req.wdata[NUM_LINES-1:0];
        end
    end

    // A new edge wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            line_pending_flags_q <= NUM_LINES'(ext_irq_pkg::FLAG_RESET);
        end else begin
            line_pending_flags_q <= ((line_pending_flags_q
                                      & ~irq_ack
                                      & ~(wr_flag ? reg_req.wdata[NUM_LINES-1:0]
                                                  : '0))
                                     | edge_hit)
                                    & ~level_line;
        end
    end

    // Level lines request straight from the pin; acked edge flags drop at once
    always_comb begin
        req_d = ((line_pending_flags_q & ~irq_ack & ~level_line) | edge_hit
                 | (level_line & ~sync2_q))
                & line_enable_reg_q & {NUM_LINES{global_irq_enable}};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_req_q <= '0;
        end else begin
            irq_req_q <= req_d;
        end
    end

    wake_level_sampler #(
        .NUM_LINES (NUM_LINES)
    ) u_wake (
        .clk          (clk),
        .rst          (rst),
        .wdt_tick     (wdt_tick),
        .powered_down (powered_down),
        .level_armed  (level_armed),
        .pin_sync     (sync2_q),
        .wake_req     (wake_raw)
    );

    // Wake alone raises no interrupt; the request still needs the level held
    always_ff @(posedge clk) begin
        if (rst) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= wake_raw;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= ext_irq_pkg::READ_UNMAPPED;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                ext_irq_pkg::SENSE_ADDR:  rdata_q <= sense_control_reg_q;
                ext_irq_pkg::ENABLE_ADDR: rdata_q <= 8'(line_enable_reg_q);
                ext_irq_pkg::FLAG_ADDR:   rdata_q <= 8'(line_pending_flags_q);
                ext_irq_pkg::STATUS_ADDR: rdata_q <= 8'(sync2_q);
                default:                  rdata_q <= ext_irq_pkg::READ_UNMAPPED;
            endcase
        end else begin
            rdata_q <= ext_irq_pkg::READ_UNMAPPED;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq_req   = irq_req_q;
    assign wake_req  = wake_q;

    // Checks
    sequence s_fall_seen(int n);
        io_clk_run && prev_q[n] && !sync2_q[n];
    endsequence

    sequence s_rise_seen(int n);
        io_clk_run && !prev_q[n] && sync2_q[n];
    endsequence

    property p_fall_sets_flag;
        @(posedge clk) disable iff (rst)
        ((sense_control_reg_q[1:0] == ext_irq_pkg::SENSE_FALLING) and s_fall_seen(0))
            |=> line_pending_flags_q[0];
    endproperty
    a_fall_sets_flag: assert property (p_fall_sets_flag) else $error("falling edge lost");

    // Lines chosen to match what the scenarios exercise
    property p_rise_sets_flag;
        @(posedge clk) disable iff (rst)
        ((sense_control_reg_q[3:2] == ext_irq_pkg::SENSE_RISING) and s_rise_seen(1))
            |=> line_pending_flags_q[1];
    endproperty
    a_rise_sets_flag: assert property (p_rise_sets_flag) else $error("rising edge lost");

    property p_change_sets_flag;
        @(posedge clk) disable iff (rst)
        (sense_control_reg_q[5:4] == ext_irq_pkg::SENSE_CHANGE && io_clk_run
         && (prev_q[2] != sync2_q[2])) |=> line_pending_flags_q[2];
    endproperty
    a_change_sets_flag: assert property (p_change_sets_flag) else $error("change lost");

    property p_level_flag_zero;
        @(posedge clk) disable iff (rst)
        (sense_control_reg_q[1:0] == 2'h0) |=> !line_pending_flags_q[0];
    endproperty
    a_level_flag_zero: assert property (p_level_flag_zero) else $error("level flag set");

    property p_level_request;
        @(posedge clk) disable iff (rst)
        (sense_control_reg_q[7:6] == ext_irq_pkg::SENSE_LOW && line_enable_reg_q[3]
         && global_irq_enable && !sync2_q[3]) |=> irq_req[3];
    endproperty
    a_level_request: assert property (p_level_request) else $error("level not requested");

    property p_w1c_clears;
        @(posedge clk) disable iff (rst)
        (wr_flag && reg_req.wdata[0] && !edge_hit[0]) |=> !line_pending_flags_q[0];
    endproperty
    a_w1c_clears: assert property (p_w1c_clears) else $error("flag not cleared");

    property p_ack_clears;
        @(posedge clk) disable iff (rst)
        (irq_ack[2] && !edge_hit[2]) |=> !line_pending_flags_q[2];
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear");

    property p_no_req_disabled;
        @(posedge clk) disable iff (rst)
        (!global_irq_enable || !line_enable_reg_q[3]) |=> !irq_req[3];
    endproperty
    a_no_req_disabled: assert property (p_no_req_disabled) else $error("masked request");

    property p_no_edge_asleep;
        @(posedge clk) disable iff (rst)
        (!io_clk_run && !line_pending_flags_q[0]) |=> !line_pending_flags_q[0];
    endproperty
    a_no_edge_asleep: assert property (p_no_edge_asleep) else $error("edge while asleep");

    property p_flag_request;
        @(posedge clk) disable iff (rst)
        (line_pending_flags_q[2] && !irq_ack[2] && line_enable_reg_q[2] && global_irq_enable)
            |=> irq_req[2];
    endproperty
    a_flag_request: assert property (p_flag_request) else $error("flag not requested");

    property p_upper_zero;
        @(posedge clk) disable iff (rst)
        ($past(reg_req.rd) && $past(reg_req.addr) != ext_irq_pkg::SENSE_ADDR)
            |-> reg_rdata[7:4] == 4'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");

    property p_ack_drops_req;
        @(posedge clk) disable iff (rst)
        (irq_ack[0] && !edge_hit[0] && !level_line[0]) |=> !irq_req[0];
    endproperty
    a_ack_drops_req: assert property (p_ack_drops_req) else $error("request kept");

    // Level lines never request from a high pin
    property p_level_no_req_high;
        @(posedge clk) disable iff (rst)
        (sense_control_reg_q[7:6] == ext_irq_pkg::SENSE_LOW && sync2_q[3]) |=> !irq_req[3];
    endproperty
    a_level_no_req_high: assert property (p_level_no_req_high) else $error("high level req");

    property p_global_masks;
        @(posedge clk) disable iff (rst)
        !global_irq_enable |=> irq_req == '0;
    endproperty
    a_global_masks: assert property (p_global_masks) else $error("request while masked");

    // Wake output needs two cycles to drain through both registers
    property p_wake_off_awake;
        @(posedge clk) disable iff (rst)
        !powered_down |=> ##1 !wake_req;
    endproperty
    a_wake_off_awake: assert property (p_wake_off_awake) else $error("wake while awake");

    property p_sense_write;
        @(posedge clk) disable iff (rst)
        wr_sense |=> sense_control_reg_q == $past(reg_req.wdata);
    endproperty
    a_sense_write: assert property (p_sense_write) else $error("sense write lost");

    property p_enable_readback;
        @(posedge clk) disable iff (rst)
        (reg_req.rd && reg_req.addr == ext_irq_pkg::ENABLE_ADDR)
            |=> reg_rdata == 8'($past(line_enable_reg_q));
    endproperty
    a_enable_readback: assert property (p_enable_readback) else $error("mask read wrong");

    property p_status_read;
        @(posedge clk) disable iff (rst)
        (reg_req.rd && reg_req.addr == ext_irq_pkg::STATUS_ADDR)
            |=> reg_rdata == 8'($past(sync2_q));
    endproperty
    a_status_read: assert property (p_status_read) else $error("pin status wrong");

endmodule : ext_pin_irq

// ==== bench/pin_source.sv ====
// Partner model: external sources driving the four interrupt pins
module pin_source (
    // Clock
    input  wire logic  clk,
    // Pins towards the block
    output logic [3:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle pins sit high, as with a pull-up
    initial pins = 4'hF;

    // Changes land just after an edge; pin direction does not matter to the block
    task automatic set_pin(input int line, input logic val);
        @(posedge clk);
        pins[line] <= val;
    endtask : set_pin

    // Low level kept long enough for the device to take it
    task automatic hold_low(input int line, input int cycles);
        set_pin(line, 1'b0);
        repeat (cycles) @(posedge clk);
        pins[line] <= 1'b1;
    endtask : hold_low
endmodule : pin_source

// ==== bench/tb_external_pin_interrupts.sv ====
// Self-checking bench for the external pin interrupt block
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin errors++; \
    $display("BAD %0t got %h exp %h", $time, got, exp); end end
module tb_external_pin_interrupts;
    timeunit 1ns;
    timeprecision 1ns;

    logic                  clk, rst, io_clk_run, powered_down, wdt_tick, global_irq_enable;
    logic [3:0]            ext_irq_pins, irq_req, irq_ack;
    ext_irq_pkg::reg_req_s reg_req;
    logic [7:0]            reg_rdata;
    logic                  wake_req;
    int                    errors, checks_done;

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    pin_source u_src (.clk(clk), .pins(ext_irq_pins));

    ext_pin_irq #(.NUM_LINES(4)) u_dut (
        .clk(clk), .rst(rst), .ext_irq_pins(ext_irq_pins), .io_clk_run(io_clk_run),
        .powered_down(powered_down), .wdt_tick(wdt_tick),
        .global_irq_enable(global_irq_enable), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .irq_req(irq_req), .irq_ack(irq_ack), .wake_req(wake_req)
    );

    task automatic final_report();
        $display("Checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    task automatic reg_write(input logic [1:0] addr, input logic [7:0] data);
        @(posedge clk);
        reg_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        reg_req.wr <= 1'b0;
    endtask : reg_write

    // Read data stands only in the cycle after the strobe
    task automatic expect_reg(input logic [1:0] addr, input logic [7:0] exp);
        @(posedge clk);
        reg_req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        reg_req.rd <= 1'b0;
        #1;
        `CHK(reg_rdata, exp)
    endtask : expect_reg

    task automatic wait_req(input int line, input logic val);
        checks_done++;
        for (int i = 0; i < 30; i++) begin
            @(posedge clk);
            #1;
            if (irq_req[line] === val) return;
        end
        errors++;
        $display("BAD %0t request %0d never reached %b", $time, line, val);
        final_report();
    endtask : wait_req

    task automatic ack(input int line);
        @(posedge clk);
        irq_ack[line] <= 1'b1;
        @(posedge clk);
        irq_ack[line] <= 1'b0;
    endtask : ack

    // Enable is dropped around every sense change
    task automatic setup(input logic [7:0] sense, input logic [7:0] en);
        reg_write(ext_irq_pkg::ENABLE_ADDR, 8'h00);
        reg_write(ext_irq_pkg::SENSE_ADDR, sense);
        reg_write(ext_irq_pkg::FLAG_ADDR, 8'h0F);
        reg_write(ext_irq_pkg::ENABLE_ADDR, en);
    endtask : setup

    task automatic t_regs();
        expect_reg(ext_irq_pkg::SENSE_ADDR, ext_irq_pkg::SENSE_RESET);
        expect_reg(ext_irq_pkg::ENABLE_ADDR, 8'h00);
        expect_reg(ext_irq_pkg::FLAG_ADDR, 8'h00);
        expect_reg(ext_irq_pkg::STATUS_ADDR, 8'h0F);
        reg_write(ext_irq_pkg::SENSE_ADDR, 8'hE4);
        expect_reg(ext_irq_pkg::SENSE_ADDR, 8'hE4);
        reg_write(ext_irq_pkg::ENABLE_ADDR, 8'hFF);
        expect_reg(ext_irq_pkg::ENABLE_ADDR, 8'h0F);
    endtask : t_regs

    task automatic t_fall();
        setup(8'h02, 8'h01);
        u_src.hold_low(0, 2);
        wait_req(0, 1'b1);
        expect_reg(ext_irq_pkg::FLAG_ADDR, 8'h01);
        ack(0);
        wait_req(0, 1'b0);
        expect_reg(ext_irq_pkg::FLAG_ADDR, 8'h00);
    endtask : t_fall

    task automatic t_rise_masked();
        @(posedge clk);
        global_irq_enable <= 1'b0;
        setup(8'h0C, 8'h02);
        u_src.hold_low(1, 4);
        repeat (6) @(posedge clk);
        expect_reg(ext_irq_pkg::FLAG_ADDR, 8'h02);
        `CHK(irq_req[1], 1'b0)
        reg_write(ext_irq_pkg::FLAG_ADDR, 8'h00);
        expect_reg(ext_irq_pkg::FLAG_ADDR, 8'h02);
        reg_write(ext_irq_pkg::FLAG_ADDR, 8'h02);
        expect_reg(ext_irq_pkg::FLAG_ADDR, 8'h00);
        @(posedge clk);
        global_irq_enable <= 1'b1;
    endtask : t_rise_masked

    task automatic t_change();
        setup(8'h10, 8'h04);
        u_src.set_pin(2, 1'b0);
        wait_req(2, 1'b1);
        ack(2);
        wait_req(2, 1'b0);
        u_src.set_pin(2, 1'b1);
        wait_req(2, 1'b1);
        ack(2);
        wait_req(2, 1'b0);
    endtask : t_change

    task automatic t_level();
        setup(8'h00, 8'h08);
        u_src.set_pin(3, 1'b0);
        wait_req(3, 1'b1);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            #1;
            `CHK(irq_req[3], 1'b1)
        end
        expect_reg(ext_irq_pkg::FLAG_ADDR, 8'h00);
        u_src.set_pin(3, 1'b1);
        wait_req(3, 1'b0);
    endtask : t_level

    // A pulse that starts and ends while the I/O clock is stopped is lost
    task automatic t_frozen();
        setup(8'h02, 8'h01);
        io_clk_run <= 1'b0;
        u_src.hold_low(0, 3);
        repeat (4) @(posedge clk);
        io_clk_run <= 1'b1;
        repeat (6) @(posedge clk);
        expect_reg(ext_irq_pkg::FLAG_ADDR, 8'h00);
        `CHK(irq_req[0], 1'b0)
    endtask : t_frozen

    task automatic t_wake();
        setup(8'h00, 8'h08);
        io_clk_run   <= 1'b0;
        powered_down <= 1'b1;
        u_src.set_pin(3, 1'b0);
        repeat (3) begin
            repeat (7) @(posedge clk);
            wdt_tick <= 1'b1;
            @(posedge clk);
            wdt_tick <= 1'b0;
        end
        repeat (3) @(posedge clk);
        #1;
        `CHK(wake_req, 1'b1)
        u_src.set_pin(3, 1'b1);
        powered_down <= 1'b0;
        io_clk_run   <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        `CHK(wake_req, 1'b0)
        `CHK(irq_req[3], 1'b0)
    endtask : t_wake

    initial begin
        rst               = 1'b1;
        io_clk_run        = 1'b1;
        powered_down      = 1'b0;
        wdt_tick          = 1'b0;
        global_irq_enable = 1'b1;
        irq_ack           = 4'h0;
        reg_req           = '0;
        errors            = 0;
        checks_done       = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_fall();
        t_rise_masked();
        t_change();
        t_level();
        t_frozen();
        t_wake();
        final_report();
    end
endmodule : tb_external_pin_interrupts
